// ===== verilog/cptc_top.v
// charger protection and supervision: thermal loop, charge watchdog, protection faults, current limits
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/100ps
`include "cptc_regs.vh"

module cptc_top #(
  parameter RECHECK_CYCLES = `CPTC_RECHECK_CYCLES,
  parameter TICK_CYCLES = `CPTC_TICK_CYCLES
) (
  // clock and reset
  input wire I_CLK,
  input wire I_RST_N,
  // register port
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  // charge control and supply state
  input wire i_enable,
  input wire i_adapter_input,
  input wire [1:0] i_charge_phase,
  input wire i_input_reduction,
  input wire i_batt_sharing,
  input wire i_timer_cap_pin_gnd,
  // protection comparators
  input wire i_die_temp_ctrl,
  input wire i_die_temp_limit,
  input wire i_battery_voltage_sense_ov,
  input wire i_temp_window_low,
  input wire i_temp_window_high,
  input wire i_thermistor_sense_gnd,
  // current settings and measurements in mA
  input wire [10:0] i_adapter_charge_set,
  input wire [10:0] i_usb_high_current_setting,
  input wire [10:0] i_adapter_limit_set,
  input wire [10:0] i_usb_limit_set,
  input wire [10:0] i_bat_current,
  input wire [10:0] i_out_current,
  // status and control outputs
  output reg o_charge_en,
  output reg [10:0] o_charge_current,
  output reg [10:0] o_path_limit,
  output reg o_overcurrent,
  output reg o_thermal_loop,
  output reg o_timer_expired,
  output reg o_fault_indicator
);

  function [10:0] min11;
    input [10:0] a;
    input [10:0] b;
    begin
      min11 = (a < b) ? a : b;
    end
  endfunction

  // timeout in ticks for a phase: cc/cv limit scales with the cap, trickle is (cc+cv)/8
  function [17:0] phase_limit;
    input [1:0] ph;
    input [3:0] cap;
    reg [21:0] cc;
    reg [22:0] tot;
    begin
      cc = `CPTC_CC_TIMEOUT_S * cap;
      tot = {cc, 1'b0};
      if (ph == `CPTC_PH_TRICKLE)
        phase_limit = tot[`CPTC_TRICKLE_DIV+17:`CPTC_TRICKLE_DIV];
      else
        phase_limit = cc[17:0];
    end
  endfunction

  reg [3:0] cap_scale_r;
  reg [9:0] step_r;
  reg tloop_active_r;
  reg [9:0] scale_r;
  reg [31:0] rchk_cnt_r;
  reg [1:0] phase_r;
  reg [31:0] tick_cnt_r;
  reg [17:0] timer_r;
  reg timeout_r;

  wire [10:0] prog_set;
  wire [10:0] path_lim;
  wire [10:0] charge_tgt;
  wire [20:0] scaled_prod;
  wire [20:0] scaled_div;
  wire [11:0] path_sum;
  wire [10:0] step_sum;
  wire temp_fault;
  wire shutdown;
  wire timer_hold;
  wire timer_run;
  wire [17:0] timer_limit;
  wire [31:0] status_word;

  // software writes: timing capacitor scale and thermal loop step
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cap_scale_r <= `CPTC_CAP_RST;
      step_r <= `CPTC_STEP_RST;
    end else if (i_wr && i_addr == `CPTC_REG_CTRL) begin
      cap_scale_r <= i_wdata[`CPTC_CTRL_CAP_MSB:`CPTC_CTRL_CAP_LSB];
      step_r <= i_wdata[`CPTC_CTRL_STEP_MSB:`CPTC_CTRL_STEP_LSB];
    end
  end

  // window comparators: safe when above the low bound and below the high bound
  // a grounded sense pin switches the monitor off entirely
  assign temp_fault = !i_thermistor_sense_gnd && (!i_temp_window_low || i_temp_window_high);
  assign shutdown = i_battery_voltage_sense_ov || i_die_temp_limit || temp_fault;

  // programmed level follows the active source
  assign prog_set = i_adapter_input ? i_adapter_charge_set : i_usb_high_current_setting;
  assign path_lim = i_adapter_input ? min11(i_adapter_limit_set, `CPTC_ADP_LIMIT_MAX_MA)
                                    : min11(i_usb_limit_set, `CPTC_USB_LIMIT_MAX_MA);
  // clamp only guards against a bad setting; the board is expected to keep the setting below the limit
  assign charge_tgt = min11(prog_set, path_lim);
  assign scaled_prod = charge_tgt * scale_r;
  assign scaled_div = scaled_prod / `CPTC_SCALE_FULL;
  assign path_sum = {1'b0, i_bat_current} + {1'b0, i_out_current};
  assign step_sum = {1'b0, scale_r} + {1'b0, step_r};

  // thermal loop: cut to 0.44 on entry, then climb one step per recheck while the die is cool
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tloop_active_r <= 1'b0;
      scale_r <= `CPTC_SCALE_FULL;
      rchk_cnt_r <= 32'h0;
    end else if (!i_enable) begin
      tloop_active_r <= 1'b0;
      scale_r <= `CPTC_SCALE_FULL;
      rchk_cnt_r <= 32'h0;
    end else if (!tloop_active_r) begin
      rchk_cnt_r <= 32'h0;
      if (i_die_temp_ctrl) begin
        tloop_active_r <= 1'b1;
        scale_r <= `CPTC_SCALE_TLOOP;
      end
    end else if (rchk_cnt_r == RECHECK_CYCLES - 1) begin
      rchk_cnt_r <= 32'h0;
      // still hot at a recheck: hold here, this is the equilibrium point
      if (!i_die_temp_ctrl) begin
        if (step_sum >= {1'b0, `CPTC_SCALE_FULL}) begin
          scale_r <= `CPTC_SCALE_FULL;
          tloop_active_r <= 1'b0;
        end else begin
          scale_r <= step_sum[9:0];
        end
      end
    end else begin
      rchk_cnt_r <= rchk_cnt_r + 32'h1;
    end
  end

  // watchdog: adapter only, pin not grounded, in a charge phase, paused by faults
  assign timer_hold = tloop_active_r || i_input_reduction || temp_fault || i_batt_sharing;
  assign timer_run = i_enable && i_adapter_input && !i_timer_cap_pin_gnd && (i_charge_phase != `CPTC_PH_IDLE) &&
                     !timer_hold && !timeout_r && !shutdown;
  assign timer_limit = phase_limit(i_charge_phase, cap_scale_r);

  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      phase_r <= `CPTC_PH_IDLE;
      tick_cnt_r <= 32'h0;
      timer_r <= 18'h0;
      timeout_r <= 1'b0;
    end else if (!i_enable) begin
      phase_r <= `CPTC_PH_IDLE;
      tick_cnt_r <= 32'h0;
      timer_r <= 18'h0;
      timeout_r <= 1'b0;
    end else begin
      phase_r <= i_charge_phase;
      if (phase_r != i_charge_phase) begin
        tick_cnt_r <= 32'h0;
        timer_r <= 18'h0;
      end else if (timer_run) begin
        if (tick_cnt_r == TICK_CYCLES - 1) begin
          tick_cnt_r <= 32'h0;
          timer_r <= timer_r + 18'h1;
          // a zero cap scale gives a zero limit; expire at the first tick rather than never
          if (timer_r + 18'h1 >= timer_limit)
            timeout_r <= 1'b1;
        end else begin
          tick_cnt_r <= tick_cnt_r + 32'h1;
        end
      end
    end
  end

  // registered outputs
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      o_charge_en <= 1'b0;
      o_charge_current <= 11'h000;
      o_path_limit <= 11'h000;
      o_overcurrent <= 1'b0;
      o_thermal_loop <= 1'b0;
      o_timer_expired <= 1'b0;
      o_fault_indicator <= 1'b0;
    end else begin
      o_charge_en <= i_enable && (i_charge_phase != `CPTC_PH_IDLE) && !shutdown && !timeout_r;
      o_charge_current <= scaled_div[10:0];
      o_path_limit <= path_lim;
      o_overcurrent <= i_enable && (path_sum > {1'b0, path_lim});
      o_thermal_loop <= tloop_active_r;
      o_timer_expired <= timeout_r;
      // charge disabled shows no fault, like a sleeping charger
      o_fault_indicator <= i_enable && (i_battery_voltage_sense_ov || temp_fault || i_die_temp_limit ||
                                        timeout_r);
    end
  end

  assign status_word = {23'h0, timer_run, o_overcurrent, temp_fault, i_die_temp_limit,
                        i_battery_voltage_sense_ov, timeout_r, tloop_active_r, o_fault_indicator, o_charge_en};

  // read data stands only in the cycle after the strobe; unmapped addresses read zero
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      o_rdata <= 32'h0;
    end else if (i_rd) begin
      case (i_addr)
        `CPTC_REG_CTRL: o_rdata <= {14'h0, step_r, 4'h0, cap_scale_r};
        `CPTC_REG_STATUS: o_rdata <= status_word;
        `CPTC_REG_TIMER: o_rdata <= {14'h0, timer_r};
        `CPTC_REG_CURRENT: o_rdata <= {5'h0, o_path_limit, 5'h0, o_charge_current};
        default: o_rdata <= 32'h0;
      endcase
    end else begin
      o_rdata <= 32'h0;
    end
  end

endmodule // cptc_top

// ===== include/cptc_regs.vh
// register map, field positions, reset values and timing constants of the charger protection block
`ifndef CPTC_REGS_VH
`define CPTC_REGS_VH

// register byte offsets
`define CPTC_REG_CTRL 8'h00
`define CPTC_REG_STATUS 8'h04
`define CPTC_REG_TIMER 8'h08
`define CPTC_REG_CURRENT 8'h0C

// control register fields and reset values
`define CPTC_CTRL_CAP_LSB 0
`define CPTC_CTRL_CAP_MSB 3
`define CPTC_CTRL_STEP_LSB 8
`define CPTC_CTRL_STEP_MSB 17
`define CPTC_CAP_RST 4'h1
`define CPTC_STEP_RST 10'h014

// status register bit positions
`define CPTC_ST_CHARGE 0
`define CPTC_ST_FAULT 1
`define CPTC_ST_TLOOP 2
`define CPTC_ST_TIMEOUT 3
`define CPTC_ST_OV 4
`define CPTC_ST_DIE_HOT 5
`define CPTC_ST_TEMP_FAULT 6
`define CPTC_ST_OVERCURRENT 7
`define CPTC_ST_TIMER_RUN 8

// charge phases reported by the charge control
`define CPTC_PH_IDLE 2'h0
`define CPTC_PH_TRICKLE 2'h1
`define CPTC_PH_CC 2'h2
`define CPTC_PH_CV 2'h3

// thermal loop current scale in thousandths of the programmed level
`define CPTC_SCALE_FULL 10'h3E8
`define CPTC_SCALE_TLOOP 10'h1B8

// path current ceilings in mA
`define CPTC_ADP_LIMIT_MAX_MA 11'h640
`define CPTC_USB_LIMIT_MAX_MA 11'h384

// timing: clock rate, recheck interval, watchdog tick and timeouts
`define CPTC_CLK_KHZ 125000
`define CPTC_RECHECK_MS 3000
`define CPTC_TICK_MS 1000
`define CPTC_CC_TIMEOUT_S 18'h02A30
`define CPTC_TRICKLE_DIV 3
`define CPTC_RECHECK_CYCLES (`CPTC_RECHECK_MS * `CPTC_CLK_KHZ)
`define CPTC_TICK_CYCLES (`CPTC_TICK_MS * `CPTC_CLK_KHZ)

`endif

// ===== test/cptc_assertions.sv
// checker of the protection outputs against their comparator and supply inputs
`timescale 1ns/100ps
module cptc_assertions (
  // clock and reset
  input wire I_CLK,
  input wire I_RST_N,
  // watched inputs
  input wire i_enable,
  input wire i_adapter_input,
  input wire i_die_temp_ctrl,
  input wire i_die_temp_limit,
  input wire i_battery_voltage_sense_ov,
  input wire i_temp_window_low,
  input wire i_temp_window_high,
  input wire i_thermistor_sense_gnd,
  input wire [10:0] i_adapter_limit_set,
  // watched outputs
  input wire o_charge_en,
  input wire [10:0] o_path_limit,
  input wire o_thermal_loop,
  input wire o_timer_expired,
  input wire o_fault_indicator
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  // a grounded sense pin switches the window off, so no fault then
  wire temp_bad = !i_thermistor_sense_gnd && !(i_temp_window_low && !i_temp_window_high);
  property p_ov; i_enable && i_battery_voltage_sense_ov |=> o_fault_indicator && !o_charge_en; endproperty
  a_ov: assert property (p_ov) else $error("over-voltage not handled");
  property p_die; i_enable && i_die_temp_limit |=> o_fault_indicator && !o_charge_en; endproperty
  a_die: assert property (p_die) else $error("die limit not handled");
  property p_temp; i_enable && temp_bad |=> o_fault_indicator && !o_charge_en; endproperty
  a_temp: assert property (p_temp) else $error("pack temperature not handled");
  property p_off; !i_enable |=> !o_fault_indicator && !o_charge_en; endproperty
  a_off: assert property (p_off) else $error("sleep not forced");
  property p_tout; o_timer_expired && $past(i_enable) |-> o_fault_indicator && !o_charge_en; endproperty
  a_tout: assert property (p_tout) else $error("timeout latch not shown");
  property p_loop; i_enable && i_die_temp_ctrl ##1 i_enable |=> o_thermal_loop; endproperty
  a_loop: assert property (p_loop) else $error("thermal loop not entered");
  property p_lim; i_adapter_input && i_adapter_limit_set > 11'h640 |=> o_path_limit == 11'h640; endproperty
  a_lim: assert property (p_lim) else $error("adapter path limit not clamped");
  // the latch sets on the edge before the output rises, from the source seen at that edge
  property p_usb; $rose(o_timer_expired) |-> $past(i_adapter_input); endproperty
  a_usb: assert property (p_usb) else $error("timeout outside adapter mode");
endmodule // cptc_assertions
bind cptc_top cptc_assertions cptc_assertions_i (.*);

// ===== test/cptc_pack_model.sv
// battery pack model: thermistor divider seen by the two window comparators
`timescale 1ns/100ps
module cptc_pack_model (
  // pack temperature 0 cold, 1 safe, 2 hot, and board sense pin grounded
  input wire [1:0] i_temp,
  input wire i_sense_off,
  // comparator view of the sense pin
  output wire o_low,
  output wire o_high,
  output wire o_gnd
);
  // sense level in thousandths of bias; the thermistor falls as the pack warms
  wire [9:0] sense = i_sense_off ? 10'h000 : (i_temp == 2'h0) ? 10'h320 : (i_temp == 2'h1) ? 10'h1F4 : 10'h0C8;
  assign o_low = sense > 10'h12C;
  assign o_high = sense > 10'h2D0;
  assign o_gnd = i_sense_off;
endmodule // cptc_pack_model

// ===== test/cptc_tb_top.sv
// self-checking bench of the charger protection block
`timescale 1ns/100ps
`include "cptc_regs.vh"
module cptc_tb_top;
  localparam TICK = 4;
  localparam RCHK = 8;
  localparam TR_LIM = 2 * 10800 / 8 * TICK;
  reg I_CLK = 1'b0;
  reg I_RST_N = 1'b0;
  reg [7:0] i_addr = 8'h00;
  reg [31:0] i_wdata = 32'h0;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg i_enable = 1'b0;
  reg i_adapter_input = 1'b1;
  reg [1:0] i_charge_phase = `CPTC_PH_CC;
  reg i_input_reduction = 1'b0;
  reg i_die_temp_ctrl = 1'b0;
  reg i_die_temp_limit = 1'b0;
  reg i_battery_voltage_sense_ov = 1'b0;
  reg [1:0] temp = 2'h1;
  reg ts_off = 1'b0;
  reg [10:0] i_adapter_charge_set = 11'h1F4;
  reg [10:0] i_adapter_limit_set = 11'h640;
  reg [10:0] i_bat_current = 11'h000;
  reg [10:0] i_out_current = 11'h000;
  wire [31:0] o_rdata;
  wire o_charge_en, o_overcurrent, o_thermal_loop, o_timer_expired, o_fault_indicator;
  wire i_temp_window_low, i_temp_window_high, i_thermistor_sense_gnd;
  wire [10:0] o_charge_current, o_path_limit;
  reg [31:0] d;
  integer n_mismatch = 0;
  integer compares = 0;
  integer i;
  integer k;
  always #4 I_CLK = ~I_CLK;
  cptc_top #(.RECHECK_CYCLES(RCHK), .TICK_CYCLES(TICK)) cptc_top_i (.*, .i_batt_sharing(1'b0),
    .i_timer_cap_pin_gnd(1'b0),
    .i_usb_high_current_setting(i_adapter_charge_set),
    .i_usb_limit_set(i_adapter_limit_set));
  cptc_pack_model cptc_pack_model_i (.i_temp(temp), .i_sense_off(ts_off), .o_low(i_temp_window_low),
    .o_high(i_temp_window_high), .o_gnd(i_thermistor_sense_gnd));
  function [10:0] path_of(input a, input [10:0] l);
    path_of = (a && l > 11'h640) ? 11'h640 : (!a && l > 11'h384) ? 11'h384 : l;
  endfunction
  task chk(input [8*10:1] name, input [31:0] exp, input [31:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task wait_n(input integer n);
    repeat (n) @(posedge I_CLK);
  endtask
  task reg_rd(input [7:0] a);
    @(posedge I_CLK);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge I_CLK);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task reg_wr(input [7:0] a, input [31:0] v);
    @(posedge I_CLK);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge I_CLK);
    i_wr <= 1'b0;
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    k = $urandom(32'h1171);
    wait_n(4);
    I_RST_N <= 1'b1;
    i_enable <= 1'b1;
    reg_rd(`CPTC_REG_CTRL);
    chk("ctrl_rst", {14'h0, `CPTC_STEP_RST, 4'h0, `CPTC_CAP_RST}, d);
    reg_rd(8'h10);
    chk("unmapped", 32'h0, d);
    reg_wr(`CPTC_REG_CTRL, 32'h00006401);
    reg_rd(`CPTC_REG_CTRL);
    chk("ctrl_wr", 32'h00006401, d);
    $display("test registers done");
    for (i = 0; i < 12; i = i + 1) begin
      k = (i == 0) ? 32'hFFFFFFFF : $urandom;
      @(posedge I_CLK);
      i_adapter_input <= k[0];
      i_adapter_limit_set <= k[11:1];
      // charge setting kept within the path limit, as the board must
      i_adapter_charge_set <= path_of(k[0], k[11:1]) >> k[13:12];
      i_bat_current <= k[22:12];
      i_out_current <= {2'h0, k[31:23]};
      wait_n(3);
      #1 chk("path_lim", path_of(k[0], k[11:1]), o_path_limit);
      chk("chg_cur", path_of(k[0], k[11:1]) >> k[13:12], o_charge_current);
      chk("overcur", {1'b0, k[22:12]} + k[31:23] > path_of(k[0], k[11:1]), o_overcurrent);
    end
    $display("test current limits done");
    @(posedge I_CLK);
    i_adapter_input <= 1'b1;
    i_adapter_limit_set <= 11'h640;
    i_adapter_charge_set <= 11'h3E8;
    i_bat_current <= 11'h000;
    for (i = 0; i < 6; i = i + 1) begin
      @(posedge I_CLK);
      i_battery_voltage_sense_ov <= (i == 0);
      i_die_temp_limit <= (i == 1);
      temp <= (i == 2 || i == 4) ? 2'h0 : (i == 3) ? 2'h2 : 2'h1;
      ts_off <= (i == 4);
      wait_n(3);
      #1 chk("fault", i < 4, o_fault_indicator);
      chk("chg_en", i >= 4, o_charge_en);
    end
    $display("test faults done");
    @(posedge I_CLK);
    i_die_temp_ctrl <= 1'b1;
    wait_n(3);
    #1 chk("loop_cur", 11'h1B8, o_charge_current);
    @(posedge I_CLK);
    i_die_temp_ctrl <= 1'b0;
    wait_n(RCHK * 8);
    #1 chk("loop_end", {1'b0, 11'h3E8}, {o_thermal_loop, o_charge_current});
    $display("test thermal loop done");
    @(posedge I_CLK);
    i_enable <= 1'b0;
    i_charge_phase <= `CPTC_PH_TRICKLE;
    wait_n(1);
    i_enable <= 1'b1;
    wait_n(3000);
    i_charge_phase <= `CPTC_PH_CC;
    wait_n(10);
    i_charge_phase <= `CPTC_PH_TRICKLE;
    wait_n(1000);
    i_input_reduction <= 1'b1;
    wait_n(500);
    i_input_reduction <= 1'b0;
    // look just after each edge so the registered latch has settled
    for (k = 1500; o_timer_expired !== 1'b1 && k < TR_LIM + 600; k = k + 1) begin
      @(posedge I_CLK);
      #1;
    end
    chk("tout_at", 1, k >= TR_LIM + 500 && k <= TR_LIM + 508);
    if (o_timer_expired !== 1'b1)
      print_verdict;
    reg_rd(`CPTC_REG_STATUS);
    chk("latched", 3'h6, {d[`CPTC_ST_TIMEOUT], o_fault_indicator, o_charge_en});
    @(posedge I_CLK);
    i_enable <= 1'b0;
    i_adapter_charge_set <= 11'h1F4;
    wait_n(2);
    i_enable <= 1'b1;
    i_adapter_input <= 1'b0;
    wait_n(3);
    #1 chk("restart", 2'h1, {o_timer_expired, o_charge_en});
    wait_n(TR_LIM + 200);
    #1 chk("usb_tout", 0, o_timer_expired);
    $display("test watchdog done");
    print_verdict;
  end
endmodule // cptc_tb_top
